// *** rtl/bg_pin_pkg.sv ***
// Shared constants and types for the background probe pin control block
package bg_pin_pkg;

    // Default widths of the extended address and of the data bus
    localparam int ADDR_W_DEF = 24;
    localparam int DATA_W_DEF = 16;
    localparam int ADDR_W_MAX = 32;

    // Forced levels used on control lines in background
    localparam logic LEVEL_HIGH = 1'b1;
    localparam logic LEVEL_LOW = 1'b0;
    localparam logic DRIVE_ON = 1'b1;
    localparam logic DRIVE_OFF = 1'b0;

    // Status bit positions within bus_status_bits
    localparam int ST_BIT0 = 0;
    localparam int ST_BIT1 = 1;
    localparam int ST_BIT2 = 2;

    // Reset values
    localparam logic MODE_FG = 1'b0;
    localparam logic CYC_DIS = 1'b0;

    // Control and status probe lines, one bit per line
    typedef struct packed {
        logic rd_wr;
        logic mem_io;
        logic [2:0] bus_status_bits;
        logic upper_byte_enable;
        logic io_read_strobe;
        logic io_write_strobe;
        logic memory_write_strobe;
        logic memory_read_strobe;
        logic bus_cycle_start;
        logic data_strobe;
        logic buffer_enable;
    } ctrl_pins_t;

    localparam ctrl_pins_t CTRL_IDLE = '1;
    localparam ctrl_pins_t CTRL_OE_OFF = '0;

    // States of the target image copy engine
    typedef enum logic [1:0] {
        CP_IDLE = 2'b00,
        CP_READ = 2'b01,
        CP_WAIT = 2'b10,
        CP_WRITE = 2'b11
    } copy_state_t;

endpackage

// *** rtl/bg_pin_ctrl.sv ***
// Background probe pin control with target image copy and debug limits
// Operation
// - In background the address bus is driven exactly as in foreground.
// - In background data bus floats, except during monitor target access.
// - Cycle output disabled: listed control and status lines float in background.
// - Cycle output enabled: read/write, memory/io and listed strobes held high.
// - Smaller variant, cycle output enabled: status bit 1 held low.
// - Larger variant, cycle output enabled: memory read strobe low during emulation memory writes.
// - Cycle output enabled: byte enable, start, strobe, buffer as foreground; status too in larger variant.
// - Every other probe pin in background follows foreground.
// - Copy request reads each target location, writes it to emulation memory.
// - Breakpoints refused in target ROM, accepted in emulation memory.
// - Coverage is recorded only for emulation memory accesses.
`timescale 1ns/1ps
module bg_pin_ctrl #(
    parameter int ADDR_W = bg_pin_pkg::ADDR_W_DEF,
    parameter int DATA_W = bg_pin_pkg::DATA_W_DEF,
    parameter bit LARGE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic bg_mode_i,
    input wire logic cyc_en_i,
    input wire logic cycle_boundary_i,
    input wire logic tgt_access_i,
    input wire logic emu_mem_write_i,
    input wire logic [ADDR_W-1:0] fg_addr_i,
    input wire logic fg_addr_oe_i,
    input wire logic [DATA_W-1:0] fg_data_i,
    input wire logic fg_data_oe_i,
    input wire bg_pin_pkg::ctrl_pins_t fg_ctrl_i,
    input wire bg_pin_pkg::ctrl_pins_t fg_ctrl_oe_i,
    input wire logic copy_req_i,
    input wire logic [ADDR_W-1:0] copy_first_i,
    input wire logic [ADDR_W-1:0] copy_last_i,
    input wire logic tgt_rd_done_i,
    input wire logic [DATA_W-1:0] tgt_rd_data_i,
    input wire logic bp_req_i,
    input wire logic bp_emu_i,
    input wire logic acc_valid_i,
    input wire logic acc_emu_i,
    input wire logic [ADDR_W-1:0] acc_addr_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output bg_pin_pkg::ctrl_pins_t ctrl_o,
    output bg_pin_pkg::ctrl_pins_t ctrl_oe_o,
    output logic copy_busy_o,
    output logic tgt_rd_o,
    output logic [ADDR_W-1:0] tgt_rd_addr_o,
    output logic emu_wr_o,
    output logic [ADDR_W-1:0] emu_wr_addr_o,
    output logic [DATA_W-1:0] emu_wr_data_o,
    output logic bp_ack_o,
    output logic bp_refused_o,
    output logic cov_wr_o,
    output logic [ADDR_W-1:0] cov_addr_o
);
    import bg_pin_pkg::*;

    // Refuse widths the address arithmetic cannot serve
    if (ADDR_W < 1 || ADDR_W > ADDR_W_MAX || DATA_W < 1) begin : g_bad
        $error("bg_pin_ctrl: unsupported address or data width");
    end

    // Next address of a copy run
    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a
    );
        next_addr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    endfunction

    logic bg_q, bg_d;
    logic cyc_en_q, cyc_en_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic addr_oe_q, addr_oe_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic data_oe_q, data_oe_d;
    ctrl_pins_t ctrl_q, ctrl_d;
    ctrl_pins_t ctrl_oe_q, ctrl_oe_d;
    logic quiet;

    // Mode and cycle-output setting change only at a bus cycle boundary
    always_comb begin
        bg_d = bg_q;
        cyc_en_d = cyc_en_q;
        if (cycle_boundary_i) begin
            bg_d = bg_mode_i;
            cyc_en_d = cyc_en_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bg_q <= MODE_FG;
            cyc_en_q <= CYC_DIS;
        end else begin
            bg_q <= bg_d;
            cyc_en_q <= cyc_en_d;
        end
    end

    // Background with no monitor target access: pins may be overridden
    assign quiet = bg_q && !tgt_access_i;

    // Pin drive: start from foreground, then apply background overrides
    always_comb begin
        addr_d = fg_addr_i;
        addr_oe_d = fg_addr_oe_i;
        data_d = fg_data_i;
        data_oe_d = fg_data_oe_i && !quiet;
        ctrl_d = fg_ctrl_i;
        ctrl_oe_d = fg_ctrl_oe_i;
        if (quiet && !cyc_en_q) begin
            // Float the cycle lines so the target sees no bus activity
            ctrl_oe_d.rd_wr = DRIVE_OFF;
            ctrl_oe_d.mem_io = DRIVE_OFF;
            ctrl_oe_d.bus_status_bits[ST_BIT0] = DRIVE_OFF;
            ctrl_oe_d.bus_status_bits[ST_BIT1] = DRIVE_OFF;
            ctrl_oe_d.upper_byte_enable = DRIVE_OFF;
            if (LARGE) begin
                ctrl_oe_d.bus_status_bits[ST_BIT2] = DRIVE_OFF;
                ctrl_oe_d.io_read_strobe = DRIVE_OFF;
                ctrl_oe_d.io_write_strobe = DRIVE_OFF;
                ctrl_oe_d.memory_write_strobe = DRIVE_OFF;
                ctrl_oe_d.memory_read_strobe = DRIVE_OFF;
                ctrl_oe_d.bus_cycle_start = DRIVE_OFF;
                ctrl_oe_d.data_strobe = DRIVE_OFF;
                ctrl_oe_d.buffer_enable = DRIVE_OFF;
            end
        end else if (quiet) begin
            // Hold lines at inactive levels; the rest stay as foreground
            ctrl_d.rd_wr = LEVEL_HIGH;
            ctrl_oe_d.rd_wr = DRIVE_ON;
            ctrl_d.mem_io = LEVEL_HIGH;
            ctrl_oe_d.mem_io = DRIVE_ON;
            if (!LARGE) begin
                ctrl_d.bus_status_bits[ST_BIT0] = LEVEL_HIGH;
                ctrl_oe_d.bus_status_bits[ST_BIT0] = DRIVE_ON;
                ctrl_d.bus_status_bits[ST_BIT1] = LEVEL_LOW;
                ctrl_oe_d.bus_status_bits[ST_BIT1] = DRIVE_ON;
            end else begin
                ctrl_d.io_read_strobe = LEVEL_HIGH;
                ctrl_oe_d.io_read_strobe = DRIVE_ON;
                ctrl_d.io_write_strobe = LEVEL_HIGH;
                ctrl_oe_d.io_write_strobe = DRIVE_ON;
                ctrl_d.memory_write_strobe = LEVEL_HIGH;
                ctrl_oe_d.memory_write_strobe = DRIVE_ON;
                if (emu_mem_write_i) begin
                    ctrl_d.memory_read_strobe = LEVEL_LOW;
                    ctrl_oe_d.memory_read_strobe = DRIVE_ON;
                end
            end
            // Byte enable, start, strobe, buffer keep fg values; status too when LARGE
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= '0;
            addr_oe_q <= DRIVE_OFF;
            data_q <= '0;
            data_oe_q <= DRIVE_OFF;
            ctrl_q <= CTRL_IDLE;
            ctrl_oe_q <= CTRL_OE_OFF;
        end else begin
            addr_q <= addr_d;
            addr_oe_q <= addr_oe_d;
            data_q <= data_d;
            data_oe_q <= data_oe_d;
            ctrl_q <= ctrl_d;
            ctrl_oe_q <= ctrl_oe_d;
        end
    end

    assign addr_o = addr_q;
    assign addr_oe_o = addr_oe_q;
    assign data_o = data_q;
    assign data_oe_o = data_oe_q;
    assign ctrl_o = ctrl_q;
    assign ctrl_oe_o = ctrl_oe_q;

    copy_state_t cp_q, cp_d;
    logic [ADDR_W-1:0] cp_addr_q, cp_addr_d;
    logic [ADDR_W-1:0] cp_last_q, cp_last_d;
    logic [DATA_W-1:0] cp_data_q, cp_data_d;
    logic tgt_rd_q, tgt_rd_d;
    logic emu_wr_q, emu_wr_d;

    // Copy engine: one target read then one emulation write per location
    always_comb begin
        cp_d = cp_q;
        cp_addr_d = cp_addr_q;
        cp_last_d = cp_last_q;
        cp_data_d = cp_data_q;
        tgt_rd_d = 1'b0;
        emu_wr_d = 1'b0;
        unique case (cp_q)
            CP_IDLE: begin
                // Range is taken as full extended addresses
                if (copy_req_i) begin
                    cp_addr_d = copy_first_i;
                    cp_last_d = copy_last_i;
                    cp_d = CP_READ;
                end
            end
            CP_READ: begin
                tgt_rd_d = 1'b1;
                cp_d = CP_WAIT;
            end
            CP_WAIT: begin
                if (tgt_rd_done_i) begin
                    cp_data_d = tgt_rd_data_i;
                    emu_wr_d = 1'b1;
                    cp_d = CP_WRITE;
                end
            end
            CP_WRITE: begin
                if (cp_addr_q == cp_last_q) begin
                    cp_d = CP_IDLE;
                end else begin
                    cp_addr_d = next_addr(cp_addr_q);
                    cp_d = CP_READ;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cp_q <= CP_IDLE;
            cp_addr_q <= '0;
            cp_last_q <= '0;
            cp_data_q <= '0;
            tgt_rd_q <= 1'b0;
            emu_wr_q <= 1'b0;
        end else begin
            cp_q <= cp_d;
            cp_addr_q <= cp_addr_d;
            cp_last_q <= cp_last_d;
            cp_data_q <= cp_data_d;
            tgt_rd_q <= tgt_rd_d;
            emu_wr_q <= emu_wr_d;
        end
    end

    logic busy_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (cp_d != CP_IDLE);
        end
    end

    assign copy_busy_o = busy_q;
    assign tgt_rd_o = tgt_rd_q;
    assign tgt_rd_addr_o = cp_addr_q;
    assign emu_wr_o = emu_wr_q;
    assign emu_wr_addr_o = cp_addr_q;
    assign emu_wr_data_o = cp_data_q;

    logic bp_ack_q, bp_ack_d;
    logic bp_ref_q, bp_ref_d;
    logic cov_wr_q, cov_wr_d;
    logic [ADDR_W-1:0] cov_addr_q, cov_addr_d;

    // Breakpoint placement check and coverage recording
    always_comb begin
        bp_ack_d = bp_req_i && bp_emu_i;
        bp_ref_d = bp_req_i && !bp_emu_i;
        cov_wr_d = acc_valid_i && acc_emu_i;
        cov_addr_d = cov_wr_d ? acc_addr_i : cov_addr_q;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bp_ack_q <= 1'b0;
            bp_ref_q <= 1'b0;
            cov_wr_q <= 1'b0;
            cov_addr_q <= '0;
        end else begin
            bp_ack_q <= bp_ack_d;
            bp_ref_q <= bp_ref_d;
            cov_wr_q <= cov_wr_d;
            cov_addr_q <= cov_addr_d;
        end
    end

    assign bp_ack_o = bp_ack_q;
    assign bp_refused_o = bp_ref_q;
    assign cov_wr_o = cov_wr_q;
    assign cov_addr_o = cov_addr_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_addr_follows_fg: assert property (
        ##1 (addr_o == $past(fg_addr_i) && addr_oe_o == $past(fg_addr_oe_i)))
        else $error("address pins differ from foreground");
    a_data_floats_bg: assert property (
        quiet |=> !data_oe_o)
        else $error("data bus driven in background");
    a_ctrl_floats_dis: assert property (
        quiet && !cyc_en_q |=> !ctrl_oe_o.rd_wr && !ctrl_oe_o.mem_io
            && !ctrl_oe_o.upper_byte_enable
            && (!LARGE || !ctrl_oe_o.data_strobe))
        else $error("control line driven with cycle output disabled");
    a_ctrl_high_en: assert property (
        quiet && cyc_en_q |=> ctrl_o.rd_wr && ctrl_o.mem_io
            && ctrl_oe_o.rd_wr && (!LARGE || ctrl_o.io_write_strobe))
        else $error("control line not held high");
    a_status1_low: assert property (
        !LARGE && quiet && cyc_en_q |=> !ctrl_o.bus_status_bits[ST_BIT1]
            && ctrl_oe_o.bus_status_bits[ST_BIT1])
        else $error("status bit 1 not held low");
    a_mrd_low_wr: assert property (
        LARGE && quiet && cyc_en_q && emu_mem_write_i
            |=> !ctrl_o.memory_read_strobe)
        else $error("memory read strobe not low on emulation write");
    a_start_as_fg: assert property (
        quiet && cyc_en_q |=> ctrl_o.bus_cycle_start
            == $past(fg_ctrl_i.bus_cycle_start))
        else $error("bus cycle start differs from foreground");
    a_target_as_fg: assert property (
        bg_q && tgt_access_i |=> data_oe_o == $past(fg_data_oe_i)
            && ctrl_o == $past(fg_ctrl_i))
        else $error("target access pins differ from foreground");
    a_copy_write: assert property (
        cp_q == CP_WAIT && tgt_rd_done_i
            |=> emu_wr_o && emu_wr_data_o == $past(tgt_rd_data_i)
            && emu_wr_addr_o == $past(tgt_rd_addr_o))
        else $error("copied word not written to emulation memory");
    a_bp_refused: assert property (
        bp_req_i |=> (bp_refused_o == !$past(bp_emu_i)) && (bp_ack_o != bp_refused_o))
        else $error("breakpoint placement answer wrong");
    a_cov_emu_only: assert property (
        acc_valid_i && !acc_emu_i |=> !cov_wr_o)
        else $error("coverage recorded for target access");
    a_mode_boundary: assert property (
        !cycle_boundary_i |=> $stable(bg_q) && $stable(cyc_en_q))
        else $error("mode changed outside a cycle boundary");

endmodule

// *** test/tgt_mem_model.sv ***
// Target bus memory model that answers copy reads after a chosen wait
`timescale 1ns/1ps
module tgt_mem_model #(
    parameter int AW = 24,
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic rd_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic slow_i,
    output logic done_o,
    output logic [DW-1:0] data_o
);
    logic pend = 1'b0;
    logic [1:0] cnt = 2'h0;
    logic [AW-1:0] a = '0;

    initial data_o = '0;

    // One answer per read; the data lines toggle so no stale word lingers
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (reset_i) begin
            pend <= 1'b0;
        end else if (rd_i) begin
            pend <= 1'b1;
            cnt <= slow_i ? 2'h3 : 2'h0;
            a <= addr_i;
        end else if (pend && cnt == 2'h0) begin
            pend <= 1'b0;
            done_o <= 1'b1;
            data_o <= a[DW-1:0] ^ 16'h5A3C;
        end else if (pend) begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for both variants of the probe pin control
`timescale 1ns/1ps
module tb;
    import bg_pin_pkg::*;
    localparam int AW = ADDR_W_DEF;
    localparam int DW = DATA_W_DEF;
    localparam int VW = 48;
    localparam int CW = $bits(ctrl_pins_t);
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic bg_mode_i, cyc_en_i, cycle_boundary_i, tgt_access_i;
    logic emu_mem_write_i, fg_addr_oe_i, fg_data_oe_i, copy_req_i;
    logic bp_req_i, bp_emu_i, acc_valid_i, acc_emu_i, slow, m_bg, m_cyc;
    logic [AW-1:0] fg_addr_i, copy_first_i, copy_last_i, acc_addr_i, ptr;
    logic [DW-1:0] fg_data_i;
    ctrl_pins_t fg_ctrl_i, fg_ctrl_oe_i;
    logic [AW-1:0] addr_o [2], tgt_rd_addr_o [2], emu_wr_addr_o [2];
    logic [AW-1:0] cov_addr_o [2];
    logic [DW-1:0] data_o [2], tgt_rd_data_i [2], emu_wr_data_o [2];
    ctrl_pins_t ctrl_o [2], ctrl_oe_o [2];
    logic addr_oe_o [2], data_oe_o [2], copy_busy_o [2], tgt_rd_o [2];
    logic tgt_rd_done_i [2], emu_wr_o [2], bp_ack_o [2], bp_refused_o [2];
    logic cov_wr_o [2];
    integer seed = 32'hebd7742a;
    int errors = 0;
    int total_checks = 0;
    int wr_cnt = 0;

    always #20 clk_i = ~clk_i;

    // Small variant at index 0, large at 1, each with its own target
    for (genvar v = 0; v < 2; v++) begin : g
        bg_pin_ctrl #(.LARGE(v == 1)) uut (.clk_i(clk_i), .reset_i(reset_i),
            .bg_mode_i(bg_mode_i), .cyc_en_i(cyc_en_i),
            .cycle_boundary_i(cycle_boundary_i), .tgt_access_i(tgt_access_i),
            .emu_mem_write_i(emu_mem_write_i), .fg_addr_i(fg_addr_i),
            .fg_addr_oe_i(fg_addr_oe_i), .fg_data_i(fg_data_i),
            .fg_data_oe_i(fg_data_oe_i), .fg_ctrl_i(fg_ctrl_i),
            .fg_ctrl_oe_i(fg_ctrl_oe_i), .copy_req_i(copy_req_i),
            .copy_first_i(copy_first_i), .copy_last_i(copy_last_i),
            .tgt_rd_done_i(tgt_rd_done_i[v]), .tgt_rd_data_i(tgt_rd_data_i[v]),
            .bp_req_i(bp_req_i), .bp_emu_i(bp_emu_i),
            .acc_valid_i(acc_valid_i), .acc_emu_i(acc_emu_i),
            .acc_addr_i(acc_addr_i), .addr_o(addr_o[v]),
            .addr_oe_o(addr_oe_o[v]), .data_o(data_o[v]),
            .data_oe_o(data_oe_o[v]), .ctrl_o(ctrl_o[v]),
            .ctrl_oe_o(ctrl_oe_o[v]), .copy_busy_o(copy_busy_o[v]),
            .tgt_rd_o(tgt_rd_o[v]), .tgt_rd_addr_o(tgt_rd_addr_o[v]),
            .emu_wr_o(emu_wr_o[v]), .emu_wr_addr_o(emu_wr_addr_o[v]),
            .emu_wr_data_o(emu_wr_data_o[v]), .bp_ack_o(bp_ack_o[v]),
            .bp_refused_o(bp_refused_o[v]), .cov_wr_o(cov_wr_o[v]),
            .cov_addr_o(cov_addr_o[v]));
        tgt_mem_model #(.AW(AW), .DW(DW)) mem (.clk_i(clk_i),
            .reset_i(reset_i), .rd_i(tgt_rd_o[v]),
            .addr_i(tgt_rd_addr_o[v]), .slow_i(slow),
            .done_o(tgt_rd_done_i[v]), .data_o(tgt_rd_data_i[v]));
    end

    task automatic conclude();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare helpers: plain values, and pin groups under an enable mask
    task automatic chk_val(string n, logic [VW-1:0] e, logic [VW-1:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic chk_pins(string n, ctrl_pins_t e, ctrl_pins_t s,
                            ctrl_pins_t m);
        total_checks++;
        if ((s & m) !== (e & m)) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e & m, s);
        end
    endtask

    function automatic logic [DW-1:0] word(logic [AW-1:0] a);
        return a[DW-1:0] ^ 16'h5A3C;
    endfunction

    // Expected level and enable of every control line for one variant
    function automatic void exp_pins(input bit lg, output ctrl_pins_t v,
                                     output ctrl_pins_t o);
        v = fg_ctrl_i;
        o = fg_ctrl_oe_i;
        if (m_bg && !tgt_access_i && !m_cyc) begin
            if (lg) begin
                o = CTRL_OE_OFF;
            end else begin
                {o.rd_wr, o.mem_io, o.upper_byte_enable} = '0;
                o.bus_status_bits[1:0] = 2'h0;
            end
        end else if (m_bg && !tgt_access_i) begin
            {v.rd_wr, v.mem_io, o.rd_wr, o.mem_io} = '1;
            if (!lg) begin
                v.bus_status_bits[1:0] = 2'h1;
                o.bus_status_bits[1:0] = 2'h3;
            end else begin
                {v.io_read_strobe, v.io_write_strobe} = '1;
                {o.io_read_strobe, o.io_write_strobe} = '1;
                {v.memory_write_strobe, o.memory_write_strobe} = '1;
                if (emu_mem_write_i) begin
                    v.memory_read_strobe = LEVEL_LOW;
                    o.memory_read_strobe = DRIVE_ON;
                end
            end
        end
    endfunction

    // Outputs now reflect the inputs still held from the last edge
    task automatic check_pins();
        ctrl_pins_t ev, eo;
        logic fl, cw;
        for (int v = 0; v < 2; v++) begin
            exp_pins(v == 1, ev, eo);
            fl = m_bg && !tgt_access_i;
            cw = acc_valid_i && acc_emu_i;
            chk_val("addr", VW'({fg_addr_oe_i, fg_addr_i}), VW'({addr_oe_o[v], addr_o[v]}));
            chk_val("data_oe", VW'(fg_data_oe_i && !fl), VW'(data_oe_o[v]));
            if (!fl && fg_data_oe_i) chk_val("data", VW'(fg_data_i), VW'(data_o[v]));
            chk_pins("ctrl_oe", eo, ctrl_oe_o[v], CTRL_IDLE);
            chk_pins("ctrl", ev, ctrl_o[v], eo);
            chk_val("bp", VW'({bp_req_i && bp_emu_i, bp_req_i && !bp_emu_i}), VW'({bp_ack_o[v], bp_refused_o[v]}));
            chk_val("cov", VW'({cw, acc_addr_i}), VW'({cov_wr_o[v], cw ? cov_addr_o[v] : acc_addr_i}));
        end
    endtask

    // One copy run with a second request that must be ignored while busy
    task automatic run_copy(logic [AW-1:0] f, logic [AW-1:0] l, logic s);
        int n;
        n = 0;
        slow = s;
        wr_cnt = 0;
        ptr = f;
        copy_first_i = f;
        copy_last_i = l;
        copy_req_i = 1'b1;
        @(negedge clk_i) copy_req_i = 1'b0;
        repeat (3) @(negedge clk_i);
        copy_first_i = ~f;
        copy_req_i = 1'b1;
        @(negedge clk_i) copy_req_i = 1'b0;
        while (copy_busy_o[0] === 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        chk_val("copy_count", VW'(AW'(l - f + 1'b1)), VW'(wr_cnt));
    endtask

    // Each emulation memory write of the small variant carries the next address and its word
    always @(negedge clk_i) begin
        if (emu_wr_o[0] === 1'b1) begin
            chk_val("emu_wr", VW'({ptr, word(ptr)}), VW'({emu_wr_addr_o[0], emu_wr_data_o[0]}));
            ptr = ptr + 1'b1;
            wr_cnt++;
        end
    end

    // Main sequence: reset, random pin traffic, then image copies
    initial begin
        {bg_mode_i, cyc_en_i, cycle_boundary_i, tgt_access_i} = '0;
        {emu_mem_write_i, fg_addr_oe_i, fg_data_oe_i, copy_req_i} = '0;
        {bp_req_i, bp_emu_i, acc_valid_i, acc_emu_i, slow} = '0;
        {fg_addr_i, copy_first_i, copy_last_i, acc_addr_i, fg_data_i} = '0;
        {fg_ctrl_i, fg_ctrl_oe_i, ptr} = '0;
        m_bg = MODE_FG;
        m_cyc = CYC_DIS;
        repeat (5) @(negedge clk_i);
        chk_pins("reset_oe", CTRL_OE_OFF, ctrl_oe_o[1], CTRL_IDLE);
        reset_i = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_i);
            if (i > 0) check_pins();
            if (cycle_boundary_i) begin
                m_bg = bg_mode_i;
                m_cyc = cyc_en_i;
            end
            {bg_mode_i, cyc_en_i, tgt_access_i, emu_mem_write_i} = 4'($random(seed));
            {fg_addr_oe_i, fg_data_oe_i, bp_req_i, bp_emu_i} = 4'($random(seed));
            {acc_valid_i, acc_emu_i} = 2'($random(seed));
            cycle_boundary_i = (($random(seed) & 3) == 0);
            fg_addr_i = AW'($random(seed));
            acc_addr_i = AW'($random(seed));
            fg_data_i = DW'($random(seed));
            fg_ctrl_i = CW'($random(seed));
            fg_ctrl_oe_i = CW'($random(seed));
        end
        {bp_req_i, acc_valid_i} = '0;
        @(negedge clk_i);
        run_copy(24'h000400, 24'h000407, 1'b0);
        run_copy(24'hFFFFFE, 24'h000001, 1'b1);
        ptr = AW'($random(seed));
        run_copy(ptr, ptr + AW'(($random(seed) & 7) + 3), 1'b0);
        conclude();
    end

    // Watchdog against a hang anywhere in the sequence
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        conclude();
    end
endmodule
